// file: rtl/twee_defines.svh
// Named constants for the two-wire EEPROM front end.
`ifndef TWEE_DEFINES_SVH
`define TWEE_DEFINES_SVH
`define TWEE_ADDR_W 10
`define TWEE_PFX_ARRAY 4'ha
`define TWEE_PFX_SERIAL 4'hb
`define TWEE_LAST_BIT 4'h7
`define TWEE_ACK_SLOT 4'h8
`define TWEE_CNT_ZERO 4'h0
`define TWEE_CNT_STEP 4'h1
`define TWEE_MASK_8K 10'h3ff
`define TWEE_MASK_4K 10'h1ff
`define TWEE_SYNC_RST 5'h18
`define TWEE_SERIAL_BITS 128
`define TWEE_FIFO_DEPTH 16
`endif

// file: rtl/twee_pkg.sv
// Types shared by the two-wire EEPROM front end.
`include "twee_defines.svh"
`default_nettype none
package twee_pkg;
    typedef enum logic [2:0] {
        ST_IDLE = 3'b000,
        ST_DEVADDR = 3'b001,
        ST_WORDADDR = 3'b010,
        ST_WRDATA = 3'b011,
        ST_RDDATA = 3'b100
    } twee_state_t;

    typedef struct packed {
        logic [`TWEE_ADDR_W-1:0] addr;
        logic [7:0] data;
    } twee_wr_t;
endpackage : twee_pkg
`default_nettype wire

// file: rtl/twee_fifo.sv
// Parameterised FIFO with a registered read stage, used as the page buffer.
`default_nettype none
module twee_fifo #(
    parameter int WIDTH = 18,
    parameter int DEPTH = 16
) (
    // Clock and reset.
    input wire logic sys_clk,
    input wire logic rst_n,
    // Filling side.
    input wire logic inValid,
    output logic inReady,
    input wire logic [WIDTH-1:0] inData,
    // Draining side.
    output logic outValid,
    input wire logic outReady,
    output logic [WIDTH-1:0] outData
);
    localparam int PW = $clog2(DEPTH);

    logic [WIDTH-1:0] store [DEPTH];
    logic [PW-1:0] wrPtr_r;
    logic [PW-1:0] rdPtr_r;
    logic [PW:0] count_r;
    logic push;
    logic pop;

    // Handshakes: the store refills the output stage whenever it is free.
    assign inReady = (count_r != (PW+1)'(DEPTH));
    assign push = inValid & inReady;
    assign pop = (count_r != '0) & (~outValid | outReady);

    // Storage writes.
    always_ff @(posedge sys_clk)
    begin
        if (push)
        begin
            store[wrPtr_r] <= inData;
        end
    end

    // Pointers and fill count.
    always_ff @(posedge sys_clk)
    begin
        if (!rst_n)
        begin
            wrPtr_r <= '0;
            rdPtr_r <= '0;
            count_r <= '0;
        end
        else
        begin
            if (push)
            begin
                wrPtr_r <= (wrPtr_r == PW'(DEPTH-1)) ? '0 : wrPtr_r + PW'(1);
            end
            if (pop)
            begin
                rdPtr_r <= (rdPtr_r == PW'(DEPTH-1)) ? '0 : rdPtr_r + PW'(1);
            end
            count_r <= count_r + (PW+1)'(push) - (PW+1)'(pop);
        end
    end

    // Registered output stage.
    always_ff @(posedge sys_clk)
    begin
        if (!rst_n)
        begin
            outValid <= 1'b0;
            outData <= '0;
        end
        else if (pop)
        begin
            outValid <= 1'b1;
            outData <= store[rdPtr_r];
        end
        else if (outReady)
        begin
            outValid <= 1'b0;
        end
    end
endmodule : twee_fifo
`default_nettype wire

// file: rtl/twee_core.sv
// Two-wire serial EEPROM front end with strap addressing, write guard and serial number.
//
// Behaviour
// - Sample incoming data on clock rise, change outgoing data on clock fall.
// - Data line is open drain: only pulled low or released.
// - Small variant compares two strap inputs, four devices per bus.
// - Large variant compares only the upper strap, two devices per bus.
// - Write guard high blocks all array writes; reads still served.
// - Small variant: 32 pages of 16 bytes, 9-bit word address.
// - Large variant: 64 pages of 16 bytes, 10-bit word address.
// - A fixed 128-bit serial number can never be written over the bus.
// - Serial number lives apart from the user array, consuming none of it.
// - Array access uses device address prefix 1010, then straps, page, R/W.
// - Serial number access uses device address prefix 1011.
// - Small: two strap bits, one page bit. Large: one strap, two page bits.
// - Each accepted byte is acknowledged by pulling data low on the ninth clock.
`include "twee_defines.svh"
`default_nettype none
module twee_core #(
    parameter bit BIG_VARIANT = 1'b0,
    parameter logic [`TWEE_SERIAL_BITS-1:0] SERIAL_NUMBER =
        128'h5a5a_0000_1111_2222_3333_4444_5555_a5a5 // Arbitrary value.
) (
    // Clock and reset.
    input wire logic sys_clk,
    input wire logic rst_n,
    // Two-wire link.
    input wire logic sclPin,
    input wire logic sdaIn,
    output logic sdaOut,
    output logic sdaOe,
    // Straps and write guard.
    input wire logic strapAddrUpper,
    input wire logic strapAddrLower,
    input wire logic writeGuard,
    // Status.
    output logic busy
);
    import twee_pkg::*;

    localparam int SYNC_N = 5;
    localparam logic [SYNC_N-1:0] SYNC_RST = `TWEE_SYNC_RST;
    localparam logic [`TWEE_ADDR_W-1:0] ADDR_MASK = BIG_VARIANT ? `TWEE_MASK_8K : `TWEE_MASK_4K;

    // ----------------------------------------------------------------
    // Input synchronisers
    // ----------------------------------------------------------------
    logic [SYNC_N-1:0] syncIn;
    logic [SYNC_N-1:0] syncA_r;
    logic [SYNC_N-1:0] syncB_r;
    logic sclS;
    logic sdaS;
    logic strapUpS;
    logic strapLoS;
    logic guardS;
    logic sclPrev_r;
    logic sdaPrev_r;

    assign syncIn = {sclPin, sdaIn, strapAddrUpper, strapAddrLower, writeGuard};

    // Two flops per pin; only the second one is read by logic.
    generate
        for (genvar i = 0; i < SYNC_N; i++)
        begin : g_sync
            always_ff @(posedge sys_clk)
            begin
                if (!rst_n)
                begin
                    syncA_r[i] <= SYNC_RST[i];
                    syncB_r[i] <= SYNC_RST[i];
                end
                else
                begin
                    syncA_r[i] <= syncIn[i];
                    syncB_r[i] <= syncA_r[i];
                end
            end
        end
    endgenerate

    assign sclS = syncB_r[4];
    assign sdaS = syncB_r[3];
    assign strapUpS = syncB_r[2];
    assign strapLoS = syncB_r[1];
    assign guardS = syncB_r[0];

    // Previous samples for edge and condition detection.
    always_ff @(posedge sys_clk)
    begin
        if (!rst_n)
        begin
            sclPrev_r <= 1'b1;
            sdaPrev_r <= 1'b1;
        end
        else
        begin
            sclPrev_r <= sclS;
            sdaPrev_r <= sdaS;
        end
    end

    logic sclRise;
    logic sclFall;
    logic startCond;
    logic stopCond;

    // Edges of the serial clock, and start or stop while the clock is high.
    assign sclRise = sclS & ~sclPrev_r;
    assign sclFall = ~sclS & sclPrev_r;
    assign startCond = sclS & sclPrev_r & sdaPrev_r & ~sdaS;
    assign stopCond = sclS & sclPrev_r & ~sdaPrev_r & sdaS;

    // ----------------------------------------------------------------
    // Address decoding
    // ----------------------------------------------------------------
    // Checks prefix and strap bits of a device address byte.
    function automatic logic addrHit(input logic [7:0] b, input logic up, input logic lo);
        logic pfxOk;
        logic strapOk;
        pfxOk = (b[7:4] == `TWEE_PFX_ARRAY) || (b[7:4] == `TWEE_PFX_SERIAL);
        strapOk = BIG_VARIANT ? (b[3] == up) : (b[3:2] == {up, lo});
        return pfxOk & strapOk;
    endfunction : addrHit

    // ----------------------------------------------------------------
    // Protocol state machine
    // ----------------------------------------------------------------
    twee_state_t state_r;
    logic [3:0] bitCnt_r;
    logic [7:0] rxShift_r;
    logic [7:0] rxByte;
    logic accept_r;
    logic serialSel_r;
    logic [1:0] pageSel_r;
    logic [`TWEE_ADDR_W-1:0] ptr_r;
    logic wrote_r;
    logic commit_r;
    logic fifoInReady;
    logic pushValid;
    logic ackDecision;
    twee_wr_t pushWord;

    assign rxByte = {rxShift_r[6:0], sdaS};

    // A data byte enters the page buffer on its eighth rise unless guarded, aimed at the serial number, or the buffer is full.
    assign pushValid = sclRise && (state_r == ST_WRDATA) && (bitCnt_r == `TWEE_LAST_BIT)
                       && fifoInReady && !serialSel_r && !guardS;
    assign pushWord = '{addr: ptr_r, data: rxByte};

    // Whether the byte now ending earns an acknowledge.
    always_comb
    begin
        case (state_r)
            ST_DEVADDR: ackDecision = addrHit(rxByte, strapUpS, strapLoS);
            ST_WORDADDR: ackDecision = 1'b1;
            ST_WRDATA: ackDecision = !serialSel_r && (fifoInReady || guardS);
            default: ackDecision = 1'b0;
        endcase
    end

    // Bit counting, address capture and pointer upkeep.
    always_ff @(posedge sys_clk)
    begin
        if (!rst_n)
        begin
            state_r <= ST_IDLE;
            bitCnt_r <= `TWEE_CNT_ZERO;
            rxShift_r <= 8'h00;
            accept_r <= 1'b0;
            serialSel_r <= 1'b0;
            pageSel_r <= 2'h0;
            ptr_r <= '0;
            wrote_r <= 1'b0;
        end
        else if (startCond)
        begin
            // While the buffer is committing, the device stays deaf.
            state_r <= commit_r ? ST_IDLE : ST_DEVADDR;
            bitCnt_r <= `TWEE_CNT_ZERO;
            accept_r <= 1'b0;
            wrote_r <= 1'b0;
        end
        else if (stopCond)
        begin
            state_r <= ST_IDLE;
            bitCnt_r <= `TWEE_CNT_ZERO;
            accept_r <= 1'b0;
            wrote_r <= 1'b0;
        end
        else if (sclRise)
        begin
            case (state_r)
                ST_DEVADDR, ST_WORDADDR, ST_WRDATA:
                begin
                    if (bitCnt_r != `TWEE_ACK_SLOT)
                    begin
                        rxShift_r <= rxByte;
                        bitCnt_r <= bitCnt_r + `TWEE_CNT_STEP;
                        if (bitCnt_r == `TWEE_LAST_BIT)
                        begin
                            accept_r <= ackDecision;
                        end
                        if (pushValid)
                        begin
                            // Page writes wrap inside the 16-byte page.
                            ptr_r <= {ptr_r[`TWEE_ADDR_W-1:4], ptr_r[3:0] + 4'h1};
                            wrote_r <= 1'b1;
                        end
                    end
                    else
                    begin
                        bitCnt_r <= `TWEE_CNT_ZERO;
                        accept_r <= 1'b0;
                        if (!accept_r)
                        begin
                            state_r <= ST_IDLE;
                        end
                        else if (state_r == ST_DEVADDR)
                        begin
                            serialSel_r <= rxShift_r[4];
                            if (rxShift_r[4])
                            begin
                                pageSel_r <= 2'h0;
                            end
                            else
                            begin
                                pageSel_r <= BIG_VARIANT ? rxShift_r[2:1]
                                                         : {1'b0, rxShift_r[1]};
                            end
                            state_r <= rxShift_r[0] ? ST_RDDATA : ST_WORDADDR;
                        end
                        else if (state_r == ST_WORDADDR)
                        begin
                            ptr_r <= ADDR_MASK & {pageSel_r, rxShift_r};
                            state_r <= ST_WRDATA;
                        end
                    end
                end
                ST_RDDATA:
                begin
                    if (bitCnt_r != `TWEE_ACK_SLOT)
                    begin
                        bitCnt_r <= bitCnt_r + `TWEE_CNT_STEP;
                    end
                    else
                    begin
                        bitCnt_r <= `TWEE_CNT_ZERO;
                        ptr_r <= ADDR_MASK & (ptr_r + `TWEE_ADDR_W'(1));
                        // A released line from the controller ends the read.
                        state_r <= sdaS ? ST_IDLE : ST_RDDATA;
                    end
                end
                default:
                begin
                    bitCnt_r <= `TWEE_CNT_ZERO;
                end
            endcase
        end
    end

    // ----------------------------------------------------------------
    // Storage and read path
    // ----------------------------------------------------------------
    logic [7:0] array [1 << `TWEE_ADDR_W];
    logic [7:0] rdByte_r;
    logic [2:0] txIdx;
    logic fifoOutValid;
    twee_wr_t fifoOut;

    // The array is written only from the drained page buffer.
    always_ff @(posedge sys_clk)
    begin
        if (fifoOutValid && commit_r)
        begin
            array[fifoOut.addr] <= fifoOut.data;
        end
    end

    // The serial number is a constant apart from the array.
    always_ff @(posedge sys_clk)
    begin
        if (!rst_n)
        begin
            rdByte_r <= 8'h00;
        end
        else if (serialSel_r)
        begin
            rdByte_r <= SERIAL_NUMBER[(`TWEE_SERIAL_BITS - 1) - 8 * ptr_r[3:0] -: 8];
        end
        else
        begin
            rdByte_r <= array[ptr_r];
        end
    end

    // Page buffer between the link and the array.
    twee_fifo #(
        .WIDTH($bits(twee_wr_t)),
        .DEPTH(`TWEE_FIFO_DEPTH)
    ) u_page_buf (
        .sys_clk(sys_clk),
        .rst_n(rst_n),
        .inValid(pushValid),
        .inReady(fifoInReady),
        .inData(pushWord),
        .outValid(fifoOutValid),
        .outReady(commit_r),
        .outData(fifoOut)
    );

    // A stop after written bytes starts the commit; it ends when drained.
    // A refused byte leaves the machine idle, yet bytes already taken still commit.
    always_ff @(posedge sys_clk)
    begin
        if (!rst_n)
        begin
            commit_r <= 1'b0;
        end
        else if (stopCond && wrote_r)
        begin
            commit_r <= 1'b1;
        end
        else if (commit_r && !fifoOutValid)
        begin
            commit_r <= 1'b0;
        end
    end

    // ----------------------------------------------------------------
    // Line driver
    // ----------------------------------------------------------------
    assign txIdx = 3'(`TWEE_LAST_BIT - bitCnt_r);

    // Drive changes only on clock fall; release on start or stop.
    always_ff @(posedge sys_clk)
    begin
        if (!rst_n)
        begin
            sdaOe <= 1'b0;
            sdaOut <= 1'b0;
            busy <= 1'b0;
        end
        else
        begin
            sdaOut <= 1'b0;
            busy <= commit_r;
            if (startCond || stopCond)
            begin
                sdaOe <= 1'b0;
            end
            else if (sclFall)
            begin
                case (state_r)
                    ST_DEVADDR, ST_WORDADDR, ST_WRDATA:
                        sdaOe <= (bitCnt_r == `TWEE_ACK_SLOT) && accept_r;
                    ST_RDDATA:
                        sdaOe <= (bitCnt_r != `TWEE_ACK_SLOT) && !rdByte_r[txIdx];
                    default:
                        sdaOe <= 1'b0;
                endcase
            end
        end
    end

    // ----------------------------------------------------------------
    // Assertions
    // ----------------------------------------------------------------
    default clocking cb @(posedge sys_clk); endclocking
    default disable iff (!rst_n);

    a_ack_slot: assert property (
        sclFall && accept_r && (bitCnt_r == `TWEE_ACK_SLOT) && (state_r != ST_RDDATA)
        && (state_r != ST_IDLE) && !startCond && !stopCond |=> sdaOe)
        else $error("Accepted byte was not acknowledged.");
    a_rx_on_rise: assert property (
        !$stable(rxShift_r) |-> $past(sclRise))
        else $error("Receive shift moved without a clock rise.");
    a_tx_on_fall: assert property (
        $rose(sdaOe) |-> $past(sclFall))
        else $error("Data line pulled low outside a clock fall.");
    a_open_drain: assert property (
        sdaOe |-> (sdaOut == 1'b0))
        else $error("Data line driven high.");
    a_guard_blocks: assert property (
        guardS |-> !pushValid)
        else $error("Write accepted while guarded.");
    a_serial_locked: assert property (
        pushValid |-> !serialSel_r)
        else $error("Write aimed at the serial number.");
    a_addr_match: assert property (
        sclRise && !startCond && !stopCond && (state_r == ST_DEVADDR)
        && (bitCnt_r == `TWEE_LAST_BIT) |=> accept_r == addrHit($past(rxByte), $past(strapUpS),
        $past(strapLoS)))
        else $error("Device address decision wrong.");
    a_word_addr: assert property (
        sclRise && !startCond && !stopCond && (state_r == ST_WORDADDR)
        && (bitCnt_r == `TWEE_ACK_SLOT) && accept_r
        |=> ptr_r == (ADDR_MASK & {$past(pageSel_r), $past(rxShift_r)}))
        else $error("Word address not formed from page and byte.");
    a_commit_busy: assert property (
        stopCond && (state_r == ST_WRDATA) && wrote_r |=> ##1 busy)
        else $error("Commit did not raise busy.");

    c_write_push: cover property (pushValid);
    c_read_byte: cover property (sclRise && (state_r == ST_RDDATA)
        && (bitCnt_r == `TWEE_ACK_SLOT));
    c_serial_read: cover property (serialSel_r && (state_r == ST_RDDATA) && sdaOe);
endmodule : twee_core
`default_nettype wire

// file: test/twee_ctrl_model.sv
// Two-wire bus controller model: drives the serial clock and pulls the data wire low.
`default_nettype none
module twee_ctrl_model (
    // Clock.
    input wire logic sys_clk,
    // Two-wire link.
    input wire logic sdaWire,
    output logic sclPin,
    output logic sdaPullLow
);
    timeunit 1ns;
    timeprecision 100ps;
    logic inFrame = 1'b0;

    // The serial clock rests high and the wire is released outside frames.
    initial
    begin
        sclPin = 1'b1;
        sdaPullLow = 1'b0;
    end

    // Waits whole system clocks, then steps just off the edge.
    task automatic tick(input int n);
        repeat (n) @(posedge sys_clk);
        #1;
    endtask : tick

    // One bit: data moves only while the clock is low, and is sampled in the high phase.
    task automatic clockBit(input logic bitVal, output logic seen);
        sclPin = 1'b0;
        tick(1);
        sdaPullLow = ~bitVal;
        tick(4);
        sclPin = 1'b1;
        tick(2);
        seen = sdaWire;
        tick(1);
    endtask : clockBit

    // Start, or repeated start when a frame is already open.
    task automatic start();
        if (inFrame)
        begin
            sclPin = 1'b0;
            tick(1);
            sdaPullLow = 1'b0;
            tick(4);
            sclPin = 1'b1;
            tick(3);
        end
        tick(4);
        sdaPullLow = 1'b1;
        tick(4);
        inFrame = 1'b1;
    endtask : start

    // Stop: the wire rises while the clock is high, then the clock stands still.
    task automatic stop();
        sclPin = 1'b0;
        tick(1);
        sdaPullLow = 1'b1;
        tick(4);
        sclPin = 1'b1;
        tick(4);
        sdaPullLow = 1'b0;
        tick(4);
        inFrame = 1'b0;
    endtask : stop

    // Sends a byte most significant bit first and returns the acknowledge.
    task automatic sendByte(input logic [7:0] b, output logic ack);
        logic s;
        for (int i = 7; i >= 0; i--)
            clockBit(b[i], s);
        clockBit(1'b1, s);
        ack = ~s;
    endtask : sendByte

    // Receives a byte, then acknowledges it or ends the read.
    task automatic recvByte(input logic ackIt, output logic [7:0] b);
        logic s;
        for (int i = 7; i >= 0; i--)
            clockBit(1'b1, b[i]);
        clockBit(~ackIt, s);
    endtask : recvByte
endmodule : twee_ctrl_model
`default_nettype wire

// file: test/tb_twee_core.sv
// Self-checking bench: a small and a large EEPROM front end share one two-wire bus.
`default_nettype none
module tb_twee_core;
    timeunit 1ns;
    timeprecision 100ps;
    localparam logic [127:0] SN = 128'h0f1e_2d3c_4b5a_6978_8796_a5b4_c3d2_e1f0; // Arbitrary value.
    logic sys_clk = 1'b0;
    logic rst_n = 1'b0;
    logic writeGuard = 1'b0;
    logic [1:0] strap4 = 2'b10;
    logic strap8 = 1'b0;
    logic sclPin, ctrlLow, oe4, oe8, out4, out8, busy4, busy8, ack, sdaWire;
    logic [7:0] expQ[$];
    logic [3:0] pfx[4] = '{4'ha, 4'hb, 4'h8, 4'he};
    int miscompares = 0;
    int cmpCount = 0;

`define CHK(g, w) check_eq(64'(g), 64'(w))

    // ------------------------------------------------------------
    // Clock, shared wire and parts
    // ------------------------------------------------------------
    always #20 sys_clk = ~sys_clk;
    // The wire has a pull-up; any party may pull it low.
    assign sdaWire = ~(oe4 | oe8 | ctrlLow);

    twee_core #(.SERIAL_NUMBER(SN)) uut (
        .sys_clk(sys_clk), .rst_n(rst_n), .sclPin(sclPin), .sdaIn(sdaWire),
        .sdaOut(out4), .sdaOe(oe4), .strapAddrUpper(strap4[1]),
        .strapAddrLower(strap4[0]), .writeGuard(writeGuard), .busy(busy4));
    twee_core #(.BIG_VARIANT(1'b1), .SERIAL_NUMBER(SN)) uut8 (
        .sys_clk(sys_clk), .rst_n(rst_n), .sclPin(sclPin), .sdaIn(sdaWire),
        .sdaOut(out8), .sdaOe(oe8), .strapAddrUpper(strap8),
        .strapAddrLower(strap4[0]), .writeGuard(writeGuard), .busy(busy8));
    twee_ctrl_model ctrl (.sys_clk(sys_clk), .sdaWire(sdaWire), .sclPin(sclPin),
        .sdaPullLow(ctrlLow));

    // The output value of an open-drain pin never drives high.
    always @(negedge sys_clk) `CHK({out4, out8}, 2'b00);

    // ------------------------------------------------------------
    // Checking and access tasks
    // ------------------------------------------------------------
    task automatic check_eq(input logic [63:0] got, input logic [63:0] wantVal);
        cmpCount++;
        if (got !== wantVal)
        begin
            miscompares++;
            $display("ERROR at %0t ns: got %0h expected %0h", $time, got, wantVal);
        end
    endtask : check_eq

    task automatic report_and_stop();
        $display("Comparisons %0d, mismatches %0d", cmpCount, miscompares);
        if (miscompares == 0 && cmpCount > 0)
            $display("TEST PASSED");
        else
            $display("TEST FAILED");
        $finish;
    endtask : report_and_stop

    // Lets the commit begin, then waits a bounded time for both parts to go idle.
    task automatic waitIdle();
        int n;
        n = 0;
        ctrl.tick(4);
        while ((busy4 !== 1'b0 || busy8 !== 1'b0) && n < 300)
        begin
            ctrl.tick(1);
            n++;
        end
        if (n == 300)
        begin
            miscompares++;
            report_and_stop();
        end
    endtask : waitIdle

    task automatic wrBytes(input logic [7:0] dev, input logic [7:0] word, input int n,
                           input logic [7:0] firstVal, input int nAck);
        ctrl.start();
        ctrl.sendByte(dev, ack);
        `CHK(ack, 1'b1);
        ctrl.sendByte(word, ack);
        `CHK(ack, 1'b1);
        for (int k = 0; k < n; k++)
        begin
            ctrl.sendByte(firstVal + 8'(k), ack);
            `CHK(ack, k < nAck);
        end
        ctrl.stop();
    endtask : wrBytes

    // Random read: dummy write of the word address, repeated start, read of expQ.
    task automatic rdCheck(input logic [7:0] dev, input logic [7:0] word);
        logic [7:0] got;
        int n;
        n = expQ.size();
        ctrl.start();
        ctrl.sendByte(dev, ack);
        `CHK(ack, 1'b1);
        ctrl.sendByte(word, ack);
        `CHK(ack, 1'b1);
        ctrl.start();
        ctrl.sendByte(dev | 8'h01, ack);
        `CHK(ack, 1'b1);
        for (int k = 0; k < n; k++)
        begin
            ctrl.recvByte(k < n - 1, got);
            `CHK(got, expQ.pop_front());
        end
        ctrl.stop();
    endtask : rdCheck

    task automatic probe(input logic [7:0] dev, input logic wantAck);
        ctrl.start();
        ctrl.sendByte(dev, ack);
        `CHK(ack, wantAck);
        ctrl.stop();
    endtask : probe

    // ------------------------------------------------------------
    // Scenarios
    // ------------------------------------------------------------
    initial
    begin
        repeat (3) @(posedge sys_clk);
        #1;
        rst_n = 1'b1;
        ctrl.tick(3);
        `CHK({oe4, oe8, busy4, busy8}, 4'h0);
        // Small part: page bit above the word byte, nine-bit wrap of reads.
        wrBytes(8'ha8, 8'h00, 1, 8'h5c, 1);
        waitIdle();
        wrBytes(8'haa, 8'hff, 2, 8'h11, 2);
        waitIdle();
        expQ = '{8'h11, 8'h5c};
        rdCheck(8'haa, 8'hff);
        expQ = '{8'h12};
        rdCheck(8'haa, 8'hf0);
        // Large part: two page bits, ten-bit wrap of reads.
        wrBytes(8'ha0, 8'h00, 1, 8'h70, 1);
        waitIdle();
        wrBytes(8'ha6, 8'hff, 1, 8'h33, 1);
        waitIdle();
        wrBytes(8'ha2, 8'hff, 1, 8'h31, 1);
        waitIdle();
        expQ = '{8'h33, 8'h70};
        rdCheck(8'ha6, 8'hff);
        expQ = '{8'h31};
        rdCheck(8'ha2, 8'hff);
        // Guarded writes are discarded, reads still served.
        writeGuard = 1'b1;
        wrBytes(8'ha8, 8'h00, 1, 8'hee, 1);
        waitIdle();
        wrBytes(8'ha0, 8'h00, 1, 8'hee, 1);
        waitIdle();
        expQ = '{8'h5c};
        rdCheck(8'ha8, 8'h00);
        expQ = '{8'h70};
        rdCheck(8'ha0, 8'h00);
        writeGuard = 1'b0;
        // Serial number cannot be written and lives apart from the array.
        wrBytes(8'hb8, 8'h00, 1, 8'hff, 0);
        waitIdle();
        foreach (pfx[d])
        begin
            if (d < 2)
            begin
                for (int k = 0; k < 16; k++)
                    expQ.push_back(SN[127 - 8 * k -: 8]);
                rdCheck(d == 0 ? 8'hb8 : 8'hb0, 8'h00);
            end
        end
        expQ = '{8'h5c};
        rdCheck(8'ha8, 8'h00);
        // Buffer fills until it refuses; a start during the commit is ignored.
        wrBytes(8'ha8, 8'h20, 18, 8'h40, 17);
        probe(8'ha8, 1'b0);
        waitIdle();
        expQ = '{8'h50};
        for (int k = 1; k < 16; k++)
            expQ.push_back(8'h40 + 8'(k));
        rdCheck(8'ha8, 8'h20);
        // Prefixes 1010, 1011, 1000 and 1110 against every strap setting.
        foreach (pfx[i])
            for (int s = 0; s < 8; s++)
            begin
                strap4 = 2'(s);
                strap8 = s[2];
                ctrl.tick(4);
                for (int c = 0; c < 4; c++)
                    probe({pfx[i], 2'(c), 2'b00}, (pfx[i][3:1] == 3'b101) &&
                          (2'(c) == strap4 || c[1] == strap8));
            end
        // Strapless package: straps low, controller sends zero strap bits.
        strap4 = 2'b00;
        strap8 = 1'b0;
        ctrl.tick(4);
        probe(8'ha0, 1'b1);
        report_and_stop();
    end
`undef CHK
endmodule : tb_twee_core
`default_nettype wire
